/* File: hdl/ecl_pkg.sv */
// Shared constants and types of the configuration loader
`default_nettype none
package ecl_pkg;
    // ****************************************
    // Store geometry
    // ****************************************
    localparam int WORDS = 32; // Words in the configuration store
    localparam int DW = 16; // Bits per word
    // ****************************************
    // Word indices within the store
    // ****************************************
    localparam logic [4:0] W_TYPE = 5'h00; // Module type and version
    localparam logic [4:0] W_INIT = 5'h01; // Auto-init flag word
    localparam logic [4:0] W_IRQ = 5'h02; // Interrupt channel
    localparam logic [4:0] W_CFGA = 5'h03; // Logic constant A
    localparam logic [4:0] W_LED = 5'h04; // LED states after reset
    localparam logic [4:0] W_CFGB = 5'h05; // Logic constant B
    localparam logic [4:0] W_CFGC = 5'h06; // Logic constant C
    localparam logic [4:0] W_TMO = 5'h07; // Timeout preset
    localparam logic [4:0] W_VGLUE = 5'h08; // Glue logic chip version
    localparam logic [4:0] W_VBUS = 5'h09; // Bus protocol chip version
    localparam logic [4:0] W_RSV_FIRST = 5'h0A; // First reserved word
    localparam logic [4:0] W_RSV_LAST = 5'h1F; // Last reserved word
    // ****************************************
    // Factory values of the store
    // ****************************************
    localparam logic [15:0] RST_CFGA = 16'h0000;
    localparam logic [15:0] RST_CFGB = 16'h95F0;
    localparam logic [15:0] RST_CFGC = 16'h15F0;
    localparam logic [15:0] RST_USER = 16'h0000; // Words 1, 2, 4, 7, reserved
    localparam int INIT_BIT = 0; // Only meaningful bit of the flag word
    // ****************************************
    // Control register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [5:0] REG_IRQSEL = 6'h20; // Interrupt select
    localparam logic [5:0] REG_LED = 6'h21; // LED control
    localparam logic [5:0] REG_TMO = 6'h22; // Timeout counter preset
    localparam logic [5:0] REG_STAT = 6'h23; // Loader status
    // ****************************************
    // Control register fields and reset values
    // ****************************************
    localparam logic [7:0] IRQ_RST = 8'h00;
    localparam logic [7:0] IRQ_WMASK = 8'h77; // Bits 3 and 7 reserved
    localparam logic [1:0] LED_RST = 2'h0;
    localparam logic [15:0] TMO_RST = 16'hFFFF;
    localparam int LED1_SEL = 0; // Write: update LED 1
    localparam int LED2_SEL = 1; // Write: update LED 2
    localparam int LED1_VAL = 2; // Write: value for LED 1
    localparam int LED2_VAL = 3; // Write: value for LED 2
    localparam int STAT_BUSY = 0; // Loader still running
    localparam int STAT_AUTO = 1; // Registers came from the store
    // ****************************************
    // Types
    // ****************************************
    // One write into the store
    typedef struct packed {
        logic en;
        logic [4:0] idx;
        logic [15:0] data;
    } ecl_wr_t;
endpackage : ecl_pkg
`default_nettype wire

/* File: hdl/ecl_word_store.sv */
// Thirty-two word configuration store with fixed factory words
`default_nettype none
module ecl_word_store #(
    parameter logic [15:0] TYPE_ID = 16'h1234, // Arbitrary value
    parameter logic [15:0] GLUE_VER = 16'h0001, // Arbitrary value
    parameter logic [15:0] BUS_VER = 16'h0003 // Arbitrary value
) (
    // Clock and power-on clear
    input wire logic clk_i,
    input wire logic por_i,
    // Write and read ports
    input wire ecl_pkg::ecl_wr_t wr_i,
    input wire logic [4:0] rd_idx_i,
    output logic [15:0] rd_data_o
);
    // Every word as seen by the read port
    logic [15:0] word_w [ecl_pkg::WORDS];

    // ****************************************
    // Per-word storage
    // ****************************************
    // Constant words get no flops, so no write can reach them
    for (genvar i = 0; i < ecl_pkg::WORDS; i++) begin : g_word
        localparam logic [4:0] IDX = 5'(i);
        if (IDX == ecl_pkg::W_TYPE) begin : g_type
            assign word_w[i] = TYPE_ID;
        end else if (IDX == ecl_pkg::W_VGLUE) begin : g_vglue
            assign word_w[i] = GLUE_VER;
        end else if (IDX == ecl_pkg::W_VBUS) begin : g_vbus
            assign word_w[i] = BUS_VER;
        end else if (IDX == ecl_pkg::W_CFGA) begin : g_cfga
            assign word_w[i] = ecl_pkg::RST_CFGA;
        end else if (IDX == ecl_pkg::W_CFGB) begin : g_cfgb
            assign word_w[i] = ecl_pkg::RST_CFGB;
        end else if (IDX == ecl_pkg::W_CFGC) begin : g_cfgc
            assign word_w[i] = ecl_pkg::RST_CFGC;
        end else begin : g_rw
            // reserved words clear to zero
            // User and reserved words: survive hardware reset
            logic [15:0] word_q;
            always_ff @(posedge clk_i) begin
                if (por_i) begin
                    word_q <= ecl_pkg::RST_USER;
                end else if (wr_i.en && wr_i.idx == IDX) begin
                    word_q <= wr_i.data;
                end
            end
            assign word_w[i] = word_q;
        end
    end

    // Read by index
    assign rd_data_o = word_w[rd_idx_i];

    // ****************************************
    // Checks
    // ****************************************
    // factory constants
    a_const_words: assert property (@(posedge clk_i) disable iff (por_i)
        (rd_idx_i == ecl_pkg::W_CFGB |-> rd_data_o == ecl_pkg::RST_CFGB) and
        (rd_idx_i == ecl_pkg::W_CFGC |-> rd_data_o == ecl_pkg::RST_CFGC))
        else $error("Factory constant word changed");
    a_type_word: assert property (@(posedge clk_i) disable iff (por_i)
        rd_idx_i == ecl_pkg::W_TYPE |-> rd_data_o == TYPE_ID)
        else $error("Type word changed");
endmodule : ecl_word_store
`default_nettype wire

/* File: hdl/ecl_loader.sv */
// Configuration loader with Wishbone register access
// Behaviour
// - store holds 32 sixteen-bit words by index
// - flag bit set: load registers after reset
// - flag bit clear: leave registers unconfigured
// - only bit 0 of flag word counts
// - word 2 feeds interrupt select
// - word 4 feeds LED states
// - word 7 feeds timeout preset
// - host may read store, program registers
// - words 3, 5, 6 fixed factory constants
// - word 0, 8, 9 read-only identity
// - settings made by software registers or loaded from the store
// - reset clears registers, timeout to FFFF
`default_nettype none
module ecl_loader #(
    parameter logic [15:0] TYPE_ID = 16'h1234, // Arbitrary value
    parameter logic [15:0] GLUE_VER = 16'h0001, // Arbitrary value
    parameter logic [15:0] BUS_VER = 16'h0003 // Arbitrary value
) (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Module settings
    output logic [7:0] irq_sel_o,
    output logic [1:0] led_o,
    output logic [15:0] tmo_init_o,
    output logic busy_o
);
    // ****************************************
    // Declarations
    // ****************************************
    // Loader sequence
    typedef enum logic [2:0] {
        ST_INIT,
        ST_IRQ,
        ST_LED,
        ST_TMO,
        ST_RUN
    } ecl_state_t;

    ecl_state_t st_q; // Loader state
    ecl_state_t st_d; // Next loader state
    logic ack_q; // Bus answer
    logic [31:0] dat_q; // Read data
    logic [7:0] irq_q; // Interrupt select register
    logic [1:0] led_q; // LED register
    logic [15:0] tmo_q; // Timeout preset register
    logic auto_q; // Registers came from the store
    logic [15:0] rd_data; // Store read port
    logic [4:0] rd_idx; // Store read index
    ecl_pkg::ecl_wr_t st_wr; // Store write

    // ****************************************
    // Bus decode
    // ****************************************
    wire [5:0] idx = adr_i[7:2]; // Word index
    wire busy = (st_q != ST_RUN); // Loader owns the store
    wire req = cyc_i && stb_i; // Request present
    wire take = req && !ack_q && !busy; // Accept this cycle
    wire wr = take && we_i; // Write commit
    wire hit_store = (idx[5] == 1'b0); // Store window 0x00..0x7C
    // Control register window 0x80..0x8C
    wire hit_irq = (idx == ecl_pkg::REG_IRQSEL);
    wire hit_led = (idx == ecl_pkg::REG_LED);
    wire hit_tmo = (idx == ecl_pkg::REG_TMO);
    wire hit_stat = (idx == ecl_pkg::REG_STAT);
    wire init_set = rd_data[ecl_pkg::INIT_BIT]; // Flag bit only

    // ****************************************
    // Store access
    // ****************************************
    // loader picks each word in turn
    always_comb begin
        case (st_q)
            ST_INIT: rd_idx = ecl_pkg::W_INIT;
            ST_IRQ: rd_idx = ecl_pkg::W_IRQ;
            ST_LED: rd_idx = ecl_pkg::W_LED;
            ST_TMO: rd_idx = ecl_pkg::W_TMO;
            default: rd_idx = idx[4:0];
        endcase
    end

    // Byte lanes merged over the old word
    assign st_wr.en = wr && hit_store;
    assign st_wr.idx = idx[4:0];
    assign st_wr.data = {sel_i[1] ? dat_i[15:8] : rd_data[15:8],
                         sel_i[0] ? dat_i[7:0] : rd_data[7:0]};

    ecl_word_store #(
        .TYPE_ID(TYPE_ID),
        .GLUE_VER(GLUE_VER),
        .BUS_VER(BUS_VER)
    ) u_store (
        .clk_i(clk_i),
        .por_i(por_i),
        .wr_i(st_wr),
        .rd_idx_i(rd_idx),
        .rd_data_o(rd_data)
    );

    // ****************************************
    // Loader sequence
    // ****************************************
    // Next state of the sequence
    always_comb begin
        case (st_q)
            ST_INIT: st_d = init_set ? ST_IRQ : ST_RUN;
            ST_IRQ: st_d = ST_LED;
            ST_LED: st_d = ST_TMO;
            ST_TMO: st_d = ST_RUN;
            ST_RUN: st_d = ST_RUN;
            default: st_d = ST_RUN;
        endcase
    end

    // One cycle per load state: a full load keeps the bus busy four cycles
    // State flop: every hardware reset restarts the load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_INIT;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    // Write data for the LED register
    wire [1:0] led_wr = {dat_i[ecl_pkg::LED2_SEL] ? dat_i[ecl_pkg::LED2_VAL] : led_q[1],
                         dat_i[ecl_pkg::LED1_SEL] ? dat_i[ecl_pkg::LED1_VAL] : led_q[0]};

    // Interrupt select: loader or software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= ecl_pkg::IRQ_RST;
        end else if (st_q == ST_IRQ) begin
            irq_q <= rd_data[7:0] & ecl_pkg::IRQ_WMASK;
        end else if (wr && hit_irq && sel_i[0]) begin
            irq_q <= dat_i[7:0] & ecl_pkg::IRQ_WMASK;
        end
    end

    // LED states: loader or software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_q <= ecl_pkg::LED_RST;
        end else if (st_q == ST_LED) begin
            led_q <= rd_data[1:0];
        // Select bits gate each LED separately
        end else if (wr && hit_led && sel_i[0]) begin
            led_q <= led_wr;
        end
    end

    // Timeout preset: loader or software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmo_q <= ecl_pkg::TMO_RST;
        end else if (st_q == ST_TMO) begin
            tmo_q <= rd_data;
        end else if (wr && hit_tmo) begin
            tmo_q <= {sel_i[1] ? dat_i[15:8] : tmo_q[15:8],
                      sel_i[0] ? dat_i[7:0] : tmo_q[7:0]};
        end
    end

    // Marks that the store supplied the settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_q <= 1'b0;
        end else if (st_q == ST_TMO) begin
            auto_q <= 1'b1;
        end
    end

    // ****************************************
    // Bus answer
    // ****************************************
    // host reads store words
    // Read mux; unmapped addresses read zero
    wire [31:0] rd_mux =
        hit_store ? {16'h0000, rd_data} :
        hit_irq ? {24'h000000, irq_q} :
        hit_led ? {30'h00000000, led_q} :
        hit_tmo ? {16'h0000, tmo_q} :
        hit_stat ? {30'h00000000, auto_q, busy} :
        32'h00000000;

    // One wait state; ack dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= take;
            // Writes leave the last read data in place
            if (take && !we_i) begin
                dat_q <= rd_mux;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Registered outputs, straight from the flops; busy_o is decoded from the state flop
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign irq_sel_o = irq_q;
    assign led_o = led_q;
    assign tmo_init_o = tmo_q;
    assign busy_o = busy;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Reset falls by a non-blocking write on its release edge, so that edge is not
    // disabled; the load checks also ask for reset low in the sampled values

    a_reset_values: assert property ($past(rst_i) |->
        tmo_q == ecl_pkg::TMO_RST && irq_q == ecl_pkg::IRQ_RST && led_q == ecl_pkg::LED_RST)
        else $error("Registers not at reset values");
    a_flag_first: assert property ($past(rst_i) |-> st_q == ST_INIT && busy_o)
        else $error("Loader did not start at flag word");
    a_no_ack_busy: assert property (ack_o |-> !$past(busy))
        else $error("Bus answered while loading");
    a_ack_answer: assert property (take |=> ack_o)
        else $error("Accepted request not answered");
    a_auto_load: assert property ((!rst_i && st_q == ST_INIT && init_set) |->
        ##4 (st_q == ST_RUN && auto_q))
        else $error("Auto load did not complete in four cycles");
    a_skip_load: assert property ((!rst_i && st_q == ST_INIT && !init_set) |=>
        st_q == ST_RUN && !auto_q && tmo_q == ecl_pkg::TMO_RST)
        else $error("Load ran with flag clear");
    a_flag_bit: assert property ((!rst_i && st_q == ST_INIT) |=>
        (st_q == ST_IRQ) == $past(rd_data[ecl_pkg::INIT_BIT]))
        else $error("Flag decision used other bits");
    a_irq_source: assert property (st_q == ST_IRQ |=>
        irq_q == ($past(rd_data[7:0]) & ecl_pkg::IRQ_WMASK))
        else $error("Interrupt select not from word 2");
    a_led_source: assert property (st_q == ST_LED |=> led_q == $past(rd_data[1:0]))
        else $error("LED states not from word 4");
    a_tmo_source: assert property (st_q == ST_TMO |=> tmo_q == $past(rd_data))
        else $error("Timeout preset not from word 7");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("Ack held longer than one cycle");
    a_regs_hold: assert property ((st_q == ST_RUN && !wr) |=>
        $stable(irq_q) && $stable(led_q) && $stable(tmo_q))
        else $error("Setting changed without a write");
    a_led_select: assert property ((wr && hit_led && sel_i[0] && !dat_i[ecl_pkg::LED1_SEL]) |=>
        led_q[0] == $past(led_q[0]))
        else $error("LED 1 changed without its select bit");
    a_dat_hold: assert property (!(take && !we_i) |=> $stable(dat_o))
        else $error("Read data changed without a read");

    // Main scenarios
    c_auto_load: cover property (st_q == ST_TMO ##1 st_q == ST_RUN);
    c_skip_load: cover property (st_q == ST_INIT && !init_set);
    c_store_write: cover property (st_wr.en && st_wr.idx == ecl_pkg::W_TMO);
    c_reg_read: cover property (take && !we_i && hit_stat);
    c_held_off: cover property (req && busy);
endmodule : ecl_loader
`default_nettype wire

/* File: verif/ecl_host_model.sv */
// Host software model: Wishbone master that saves and programs settings
`default_nettype none
module ecl_host_model (
    // Clock
    input wire logic clk_i,
    // Answer from the loader
    input wire logic [31:0] rdat_i,
    input wire logic ack_i,
    // Request to the loader
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] wdat_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Bus cycles
    // ****************************************
    // Idle bus from time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        wdat_o = 32'h0000_0000;
    end
    // One write; the bus stays quiet a cycle before the next request
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= 1'b1;
        adr_o <= a;
        sel_o <= s;
        wdat_o <= d;
        // No fixed latency: the loader may still be busy
        do @(posedge clk_i); while (ack_i !== 1'b1);
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
    endtask : bus_wr
    // One read; data taken at the acknowledging edge
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= 1'b0;
        adr_o <= a;
        sel_o <= 4'hF;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        d = rdat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask : bus_rd
    // ****************************************
    // Host procedures
    // ****************************************
    // only user words are saved; factory words untouched
    task automatic save_cfg(input logic [15:0] flag, input logic [15:0] irq, input logic [15:0] led,
                            input logic [15:0] tmo);
        bus_wr(8'h04, {16'h0000, flag}, 4'h3);
        bus_wr(8'h08, {16'h0000, irq}, 4'h3);
        bus_wr(8'h10, {16'h0000, led}, 4'h3);
        bus_wr(8'h1C, {16'h0000, tmo}, 4'h3);
    endtask : save_cfg
endmodule : ecl_host_model
`default_nettype wire

/* File: verif/ecl_loader_tb_top.sv */
// Self-checking bench of the configuration loader
`default_nettype none
module ecl_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Clock, resets and wires
    // ****************************************
    localparam logic [15:0] ID_TYPE = 16'h0A5A; // Arbitrary value
    localparam logic [15:0] ID_GLUE = 16'h0011; // Arbitrary value
    localparam logic [15:0] ID_BUS = 16'h0022; // Arbitrary value
    logic clk_i = 1'b0; // 50 ns period
    logic rst_i = 1'b1; // Hardware reset
    logic por_i = 1'b1; // Store clear, first reset only
    logic cyc, stb, we, ack, busy;
    logic [7:0] adr, irq;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, got;
    logic [1:0] led;
    logic [15:0] tmo;
    int n_fail = 0;
    int n_checks = 0;
    always #25 clk_i = ~clk_i;
    // Loader under test
    ecl_loader #(.TYPE_ID(ID_TYPE), .GLUE_VER(ID_GLUE), .BUS_VER(ID_BUS)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .irq_sel_o(irq), .led_o(led), .tmo_init_o(tmo), .busy_o(busy));
    // Host side
    ecl_host_model host (
        .clk_i(clk_i), .rdat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .wdat_o(wdat));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv) begin
            n_fail++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, expv);
        end
    endtask : check
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        host.bus_rd(a, got);
        check(got, e);
    endtask : rchk
    // Short reset; por stays low, so the store survives
    task automatic hw_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : hw_reset
    // Bounded wait for the loader to finish
    task automatic wait_idle();
        for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
            @(posedge clk_i);
        end
        #1;
        check({31'h0, busy}, 32'h0);
    endtask : wait_idle
    task automatic print_verdict();
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // Watchdog at 5000 cycles, far beyond the roughly 130 cycles needed
    initial begin
        #(50 * 5000);
        n_fail++;
        print_verdict();
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (15) @(posedge clk_i);
        #1;
        check({irq, led, tmo, 5'h00, busy}, {8'h00, 2'h0, 16'hFFFF, 5'h00, 1'b1});
        @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        wait_idle();
        check({irq, led, tmo, 6'h00}, {8'h00, 2'h0, 16'hFFFF, 6'h00});
        rchk(8'h8C, 32'h0);
        // Identity and factory words, then refused writes
        rchk(8'h00, {16'h0, ID_TYPE});
        rchk(8'h20, {16'h0, ID_GLUE});
        rchk(8'h24, {16'h0, ID_BUS});
        rchk(8'h0C, 32'h0);
        rchk(8'h14, 32'h95F0);
        rchk(8'h18, 32'h15F0);
        rchk(8'h28, 32'h0);
        host.bus_wr(8'h14, 32'hFFFF_FFFF, 4'hF);
        host.bus_wr(8'h00, 32'hFFFF_FFFF, 4'hF);
        rchk(8'h14, 32'h95F0);
        rchk(8'h00, {16'h0, ID_TYPE});
        // Last word reachable; single lane keeps the other byte
        host.bus_wr(8'h7C, 32'hFFFF_BEEF, 4'h3);
        host.bus_wr(8'h7C, 32'h0000_1234, 4'h1);
        rchk(8'h7C, 32'hBE34);
        // Flag word with every bit but bit 0 set: no load
        host.save_cfg(16'hFFFE, 16'h00FF, 16'h0003, 16'h1234);
        hw_reset();
        wait_idle();
        check({irq, led, tmo, 6'h00}, {8'h00, 2'h0, 16'hFFFF, 6'h00});
        rchk(8'h04, 32'hFFFE);
        // Flag set: load after reset, bus held off meanwhile
        host.bus_wr(8'h04, 32'h0000_0001, 4'h3);
        hw_reset();
        #1;
        check({31'h0, busy}, 32'h1);
        rchk(8'h8C, 32'h2);
        check({31'h0, busy}, 32'h0);
        check({24'h0, irq}, 32'h77);
        check({30'h0, led}, 32'h3);
        check({16'h0, tmo}, 32'h1234);
        // Software programming of the settings
        host.bus_wr(8'h80, 32'h0000_00FA, 4'hF);
        rchk(8'h80, 32'h72);
        // Low lane not selected: interrupt select keeps its value
        host.bus_wr(8'h80, 32'h0000_0005, 4'h2);
        rchk(8'h80, 32'h72);
        host.bus_wr(8'h84, 32'h0000_0001, 4'hF);
        rchk(8'h84, 32'h2);
        // LED 2 selected off; LED 1 value bit ignored without its select
        host.bus_wr(8'h84, 32'h0000_0006, 4'hF);
        rchk(8'h84, 32'h0);
        check({30'h0, led}, 32'h0);
        host.bus_wr(8'h88, 32'h0000_0BAD, 4'hF);
        #1;
        check({16'h0, tmo}, 32'h0BAD);
        // Unmapped place reads zero and drops writes
        host.bus_wr(8'h90, 32'hFFFF_FFFF, 4'hF);
        rchk(8'h90, 32'h0);
        print_verdict();
    end
endmodule : ecl_loader_tb_top
`default_nettype wire
